// file: hw/uart_regbank_pkg.sv
// How it works
// - baud integer part is a 16-bit read-write field.
// - baud fractional part is a 4-bit read-write field.
// - timer reload is 24 bits, resets to all ones, upper bits zero.
// - timer count readable; overflow flag set when count reaches or passes reload.
// - custom parity: transmit word bit 8 goes out as the parity bit.
// - break field length in bit times is the written transmit word.
// - custom parity: received parity bit lands in receive word bit 8.
// - one read-write enable bit per interrupt source, except address match bit 5, clear-to-send level bit 7 and busy bit 8, which have none.
// - in LIN mode a received break field sets flag bit 11.
// - finished auto-baud detection sets flag bit 10.
// - busy bit 8 high while holding or shift register holds data.
// - bit 7 shows present clear-to-send level.
// - any clear-to-send level change sets flag bit 6.
// - received address match sets flag bit 5.
// - receive parity error sets flag bit 4.
// - receive stop-bit error sets flag bit 3.
// - completed receive frame sets flag bit 2.
// - completed transmit frame sets flag bit 1.
// - empty bit 0 high without buffered data, resets one, cleared by write.
// - writing zero to a clear-bank bit clears that flag; one does nothing.
package uart_regbank_pkg;

    // ***********************************
    // register offsets
    // ***********************************
    localparam logic [7:0] OFS_MODE = 8'h3c;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h08;
    localparam logic [7:0] OFS_BAUD_INT = 8'h0c;
    localparam logic [7:0] OFS_BAUD_FRAC = 8'h10;
    localparam logic [7:0] OFS_TIMER_RELOAD = 8'h14;
    localparam logic [7:0] OFS_TIMER_COUNT = 8'h18;
    localparam logic [7:0] OFS_IRQ_FLAG = 8'h1c;
    localparam logic [7:0] OFS_FLAG_CLEAR = 8'h20;
    localparam logic [7:0] OFS_RECEIVE = 8'h24;
    localparam logic [7:0] OFS_TRANSMIT = 8'h28;

    // ***********************************
    // widths and field positions
    // ***********************************
    localparam int ADDR_W = 8;
    localparam int BAUD_INT_W = 16;
    localparam int BAUD_FRAC_W = 4;
    localparam int TIMER_W = 24;
    localparam int WORD_W = 9;
    localparam int FLAG_W = 12;
    localparam int BIT_BRK = 11;
    localparam int BIT_BAUD = 10;
    localparam int BIT_TIMER_OVERFLOW_FLAG = 9;
    localparam int BIT_BUSY = 8;
    localparam int BIT_CLEAR_TO_SEND_LEVEL = 7;
    localparam int BIT_CTS = 6;
    localparam int BIT_MATCH = 5;
    localparam int BIT_PE = 4;
    localparam int BIT_FE = 3;
    localparam int BIT_RC = 2;
    localparam int BIT_TC = 1;
    localparam int BIT_TXE = 0;
    localparam int BIT_MODE_PARITY = 0;
    localparam int BIT_MODE_LIN = 1;

    // ***********************************
    // reset values and masks
    // ***********************************
    localparam logic [23:0] RST_TIMER_RELOAD = 24'hff_ffff;
    localparam logic [11:0] IRQ_ENABLE_MASK = 12'he5f;
    localparam logic [11:0] STICKY_MASK = 12'he7e;
    localparam logic [11:0] CLEARABLE_MASK = 12'he5e;
    localparam logic [31:0] FLAG_CLEAR_READ = 32'h0000_0fff;

endpackage : uart_regbank_pkg

// file: hw/uart_register_status_bank.sv
// Design decision made here: the plain strobed port.
`timescale 1ns/1ns
module uart_register_status_bank (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    // register port
    input wire logic [uart_regbank_pkg::ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // clear-to-send pin
    input wire logic i_cts_pin,
    // receive engine events
    input wire logic i_rx_done,
    input wire logic [7:0] i_rx_data,
    input wire logic i_rx_parity,
    input wire logic i_rx_parity_err,
    input wire logic i_rx_frame_err,
    input wire logic i_rx_break,
    input wire logic i_rx_addr_match,
    input wire logic i_autobaud_done,
    // transmit engine handshake
    output logic o_tx_valid,
    input wire logic i_tx_take,
    input wire logic i_tx_shift_busy,
    input wire logic i_tx_done,
    output logic [uart_regbank_pkg::WORD_W-1:0] o_tx_word,
    output logic o_tx_parity_bit,
    output logic o_tx_custom_parity,
    output logic o_lin_mode,
    output logic [uart_regbank_pkg::WORD_W-1:0] o_break_bit_times,
    // timer engine control
    input wire logic i_timer_run,
    input wire logic i_timer_restart,
    // divisor outputs
    output logic [uart_regbank_pkg::BAUD_INT_W-1:0] o_baud_int_part,
    output logic [uart_regbank_pkg::BAUD_FRAC_W-1:0] o_baud_frac_part,
    // interrupt request
    output logic o_irq
);
    import uart_regbank_pkg::*;

    // ***********************************
    // state
    // ***********************************
    typedef struct packed {
        logic [1:0] mode;
        logic [FLAG_W-1:0] irq_enable_bank;
        logic [BAUD_INT_W-1:0] baud_int_part;
        logic [BAUD_FRAC_W-1:0] baud_frac_part;
        logic [TIMER_W-1:0] timer_reload;
        logic [TIMER_W-1:0] timer_count;
        logic [FLAG_W-1:0] sticky;
        logic [WORD_W-1:0] tx_word;
        logic tx_full;
        logic [WORD_W-1:0] receive_word;
        logic cts_s1;
        logic cts_s2;
        logic cts_prev;
        logic [31:0] rdata;
    } bank_s;

    bank_s state_q;
    bank_s state_d;

    logic [FLAG_W-1:0] flag_set;
    logic [FLAG_W-1:0] flag_clear;
    logic [FLAG_W-1:0] irq_flag_bank;
    logic timer_overflow_flag;
    logic transmit_busy_flag;
    logic transmit_empty_flag;
    logic clear_to_send_level;
    logic custom_parity;
    logic lin_mode;
    logic wr_transmit;
    logic sel_mode;
    logic sel_irq_enable;
    logic sel_baud_int;
    logic sel_baud_frac;
    logic sel_timer_reload;
    logic sel_timer_count;
    logic sel_irq_flag;
    logic sel_flag_clear;
    logic sel_receive;
    logic sel_transmit;
    logic we_mode;
    logic we_irq_enable;
    logic we_baud_int;
    logic we_baud_frac;
    logic we_timer_reload;
    logic we_flag_clear;
    logic re_receive;
    logic [31:0] rd_mux;
    logic [FLAG_W-1:0] sticky_next;
    logic [FLAG_W-1:0] irq_hit;
    logic [TIMER_W-1:0] timer_next;
    logic [WORD_W-1:0] rx_capture;

    // ***********************************
    // address decode
    // ***********************************
    // one-hot select; an unmapped offset selects nothing, so it reads zero and writes nowhere
    always_comb begin
        sel_mode = 1'b0;
        sel_irq_enable = 1'b0;
        sel_baud_int = 1'b0;
        sel_baud_frac = 1'b0;
        sel_timer_reload = 1'b0;
        sel_timer_count = 1'b0;
        sel_irq_flag = 1'b0;
        sel_flag_clear = 1'b0;
        sel_receive = 1'b0;
        sel_transmit = 1'b0;
        if (i_addr == OFS_MODE) begin
            sel_mode = 1'b1;
        end else if (i_addr == OFS_IRQ_ENABLE) begin
            sel_irq_enable = 1'b1;
        end else if (i_addr == OFS_BAUD_INT) begin
            sel_baud_int = 1'b1;
        end else if (i_addr == OFS_BAUD_FRAC) begin
            sel_baud_frac = 1'b1;
        end else if (i_addr == OFS_TIMER_RELOAD) begin
            sel_timer_reload = 1'b1;
        end else if (i_addr == OFS_TIMER_COUNT) begin
            sel_timer_count = 1'b1;
        end else if (i_addr == OFS_IRQ_FLAG) begin
            sel_irq_flag = 1'b1;
        end else if (i_addr == OFS_FLAG_CLEAR) begin
            sel_flag_clear = 1'b1;
        end else if (i_addr == OFS_RECEIVE) begin
            sel_receive = 1'b1;
        end else if (i_addr == OFS_TRANSMIT) begin
            sel_transmit = 1'b1;
        end
    end

    // read-only offsets get no write enable, so writes there fall away
    always_comb begin
        we_mode = i_wr & sel_mode;
        we_irq_enable = i_wr & sel_irq_enable;
        we_baud_int = i_wr & sel_baud_int;
        we_baud_frac = i_wr & sel_baud_frac;
        we_timer_reload = i_wr & sel_timer_reload;
        we_flag_clear = i_wr & sel_flag_clear;
        wr_transmit = i_wr & sel_transmit;
        re_receive = i_rd & sel_receive;
    end

    // ***********************************
    // read mux
    // ***********************************
    // transmit offset is write-only and falls through to zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (sel_irq_enable) begin
            rd_mux = {20'h0_0000, state_q.irq_enable_bank};
        end else if (sel_baud_int) begin
            rd_mux = {16'h0000, state_q.baud_int_part};
        end else if (sel_baud_frac) begin
            rd_mux = {28'h000_0000, state_q.baud_frac_part};
        end else if (sel_timer_reload) begin
            rd_mux = {8'h00, state_q.timer_reload};
        end else if (sel_timer_count) begin
            rd_mux = {8'h00, state_q.timer_count};
        end else if (sel_irq_flag) begin
            rd_mux = {20'h0_0000, irq_flag_bank};
        end else if (sel_flag_clear) begin
            rd_mux = FLAG_CLEAR_READ;
        end else if (sel_receive) begin
            rd_mux = {23'h0, state_q.receive_word};
        end else if (sel_mode) begin
            rd_mux = {30'h0, state_q.mode};
        end
    end

    // ***********************************
    // per-flag logic
    // ***********************************
    for (genvar b = 0; b < FLAG_W; b++) begin : g_flag
        if (STICKY_MASK[b]) begin : g_sticky
            // set beats clear when both land in one cycle
            assign sticky_next[b] = flag_set[b] | (state_q.sticky[b] & ~flag_clear[b]);
        end else begin : g_live
            // live bits hold no state of their own
            assign sticky_next[b] = 1'b0;
        end
        assign irq_hit[b] = irq_flag_bank[b] & state_q.irq_enable_bank[b];
    end

    // ***********************************
    // timer and receive helpers
    // ***********************************
    always_comb begin
        timer_next = state_q.timer_count;
        // restart beats run; the count parks once it reaches the reload value
        if (i_timer_restart) begin
            timer_next = '0;
        end else if (i_timer_run && !timer_overflow_flag) begin
            timer_next = state_q.timer_count + 24'h00_0001;
        end
        // without custom parity the ninth bit stays zero
        rx_capture = {custom_parity & i_rx_parity, i_rx_data};
    end

    // ***********************************
    // status view
    // ***********************************
    always_comb begin
        custom_parity = state_q.mode[BIT_MODE_PARITY];
        lin_mode = state_q.mode[BIT_MODE_LIN];
        clear_to_send_level = state_q.cts_s2;
        // level compare, not an edge, so a late reload change is still caught
        timer_overflow_flag = (state_q.timer_count >= state_q.timer_reload);
        transmit_busy_flag = state_q.tx_full | i_tx_shift_busy;
        transmit_empty_flag = ~state_q.tx_full;

        flag_set = '0;
        flag_set[BIT_BRK] = i_rx_break & lin_mode;
        flag_set[BIT_BAUD] = i_autobaud_done;
        flag_set[BIT_TIMER_OVERFLOW_FLAG] = timer_overflow_flag;
        flag_set[BIT_CTS] = state_q.cts_s2 ^ state_q.cts_prev;
        flag_set[BIT_MATCH] = i_rx_addr_match;
        flag_set[BIT_PE] = i_rx_parity_err;
        flag_set[BIT_FE] = i_rx_frame_err;
        flag_set[BIT_RC] = i_rx_done;
        flag_set[BIT_TC] = i_tx_done;

        flag_clear = '0;
        if (we_flag_clear) begin
            flag_clear = ~i_wdata[FLAG_W-1:0] & CLEARABLE_MASK;
        end
        // match has no clear-bank bit; reading the received word retires it
        if (re_receive) begin
            flag_clear[BIT_MATCH] = 1'b1;
        end

        irq_flag_bank = state_q.sticky & STICKY_MASK;
        irq_flag_bank[BIT_BUSY] = transmit_busy_flag;
        irq_flag_bank[BIT_CLEAR_TO_SEND_LEVEL] = clear_to_send_level;
        irq_flag_bank[BIT_TXE] = transmit_empty_flag;
    end

    // ***********************************
    // next state
    // ***********************************
    always_comb begin
        state_d = state_q;

        // two-stage sync; only the second stage feeds logic
        state_d.cts_s1 = i_cts_pin;
        state_d.cts_s2 = state_q.cts_s1;
        state_d.cts_prev = state_q.cts_s2;

        state_d.sticky = sticky_next;
        state_d.timer_count = timer_next;

        if (i_rx_done) begin
            state_d.receive_word = rx_capture;
        end

        // engine take and a new write in one cycle: the write refills the buffer
        if (wr_transmit) begin
            state_d.tx_word = i_wdata[WORD_W-1:0];
            state_d.tx_full = 1'b1;
        end else if (i_tx_take && state_q.tx_full) begin
            state_d.tx_full = 1'b0;
        end

        if (we_irq_enable) begin
            state_d.irq_enable_bank = i_wdata[FLAG_W-1:0] & IRQ_ENABLE_MASK;
        end
        if (we_baud_int) begin
            state_d.baud_int_part = i_wdata[BAUD_INT_W-1:0];
        end
        if (we_baud_frac) begin
            state_d.baud_frac_part = i_wdata[BAUD_FRAC_W-1:0];
        end
        if (we_timer_reload) begin
            state_d.timer_reload = i_wdata[TIMER_W-1:0];
        end
        if (we_mode) begin
            state_d.mode = i_wdata[1:0];
        end

        // read data stand for exactly the cycle after the strobe
        state_d.rdata = i_rd ? rd_mux : 32'h0000_0000;

        if (!i_nrst) begin
            state_d = '0;
            state_d.timer_reload = RST_TIMER_RELOAD;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        state_q <= state_d;
    end

    // ***********************************
    // outputs
    // ***********************************
    always_comb begin
        o_rdata = state_q.rdata;
        o_baud_int_part = state_q.baud_int_part;
        o_baud_frac_part = state_q.baud_frac_part;
        o_tx_valid = state_q.tx_full;
        o_tx_word = state_q.tx_word;
        o_tx_custom_parity = custom_parity;
        // engine uses its own parity unless custom is selected
        o_tx_parity_bit = custom_parity & state_q.tx_word[WORD_W-1];
        o_lin_mode = lin_mode;
        o_break_bit_times = state_q.tx_word;
        o_irq = |irq_hit;
    end

endmodule : uart_register_status_bank

// file: tb/uart_regbank_props.sv
`timescale 1ns/1ns
module uart_regbank_props (
    // watched ports
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic [uart_regbank_pkg::ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_tx_take,
    input wire logic [31:0] o_rdata,
    input wire logic o_tx_valid,
    input wire logic [uart_regbank_pkg::WORD_W-1:0] o_tx_word,
    input wire logic o_tx_parity_bit,
    input wire logic o_tx_custom_parity,
    input wire logic [uart_regbank_pkg::WORD_W-1:0] o_break_bit_times,
    input wire logic [uart_regbank_pkg::BAUD_INT_W-1:0] o_baud_int_part,
    input wire logic o_irq
);
    import uart_regbank_pkg::*;
    default clocking @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_nrst);
    // write of the holding word, take in the same cycle must not empty it
    logic tx_wr;
    assign tx_wr = i_wr && (i_addr == OFS_TRANSMIT);
    property p_rd_idle; !$past(i_rd) |-> o_rdata == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    property p_tx_load; tx_wr |=> o_tx_valid; endproperty
    a_tx_load: assert property (p_tx_load) else $error("holding word not full");
    property p_tx_word; tx_wr |=> o_break_bit_times == $past(i_wdata[8:0]); endproperty
    a_tx_word: assert property (p_tx_word) else $error("break length not written word");
    property p_take; o_tx_valid && i_tx_take && !tx_wr |=> !o_tx_valid; endproperty
    a_take: assert property (p_take) else $error("taken word still waits");
    property p_hold; o_tx_valid && !i_tx_take |=> o_tx_valid; endproperty
    a_hold: assert property (p_hold) else $error("holding word lost");
    property p_par; o_tx_parity_bit == (o_tx_custom_parity && o_tx_word[8]); endproperty
    a_par: assert property (p_par) else $error("parity bit not word bit 8");
    property p_irq_off; i_wr && i_addr == OFS_IRQ_ENABLE && i_wdata[11:0] == 12'h000 |=> !o_irq; endproperty
    a_irq_off: assert property (p_irq_off) else $error("request without enable");
    property p_baud; i_wr && i_addr == OFS_BAUD_INT |=> o_baud_int_part == $past(i_wdata[15:0]); endproperty
    a_baud: assert property (p_baud) else $error("divisor not updated");
endmodule : uart_regbank_props

// file: tb/tx_engine_model.sv
`timescale 1ns/1ns
module tx_engine_model #(
    parameter int LAT = 6,
    parameter int LEN = 12
) (
    // engine side of the transmit handshake
    input wire logic i_ref_clk,
    input wire logic i_valid,
    output logic o_take,
    output logic o_busy,
    output logic o_done
);
    int cnt = 0;
    initial begin
        o_take = 1'b0;
        o_busy = 1'b0;
        o_done = 1'b0;
    end
    // slow take on purpose, so the full holding word is seen by software
    always @(posedge i_ref_clk) begin
        o_take <= 1'b0;
        o_done <= 1'b0;
        cnt <= cnt + 1;
        if (o_busy && cnt == LEN) begin
            o_busy <= 1'b0;
            o_done <= 1'b1;
            cnt <= 0;
        end else if (!o_busy && i_valid && cnt >= LAT) begin
            o_take <= 1'b1;
            o_busy <= 1'b1;
            cnt <= 0;
        end else if (!o_busy && !i_valid) begin
            cnt <= 0;
        end
    end
endmodule : tx_engine_model

// file: tb/test_uart_register_status_bank.sv
`timescale 1ns/1ns
module test_uart_register_status_bank;
    import uart_regbank_pkg::*;
    logic i_ref_clk, i_nrst, i_wr, i_rd, i_cts_pin, i_timer_run, i_timer_restart, i_rx_parity, o_irq;
    logic i_rx_done, i_rx_parity_err, i_rx_frame_err, i_rx_break, i_rx_addr_match, i_autobaud_done;
    logic i_tx_take, i_tx_shift_busy, i_tx_done, o_tx_valid, o_tx_parity_bit, o_tx_custom_parity, o_lin_mode;
    logic [7:0] i_addr, i_rx_data;
    logic [31:0] i_wdata, o_rdata;
    logic [WORD_W-1:0] o_tx_word, o_break_bit_times;
    logic [BAUD_INT_W-1:0] o_baud_int_part;
    logic [BAUD_FRAC_W-1:0] o_baud_frac_part;
    logic [5:0] ev;
    int failures = 0;
    int n_tests = 0;
    int w;
    logic [7:0] ra [8] = '{8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h24, 8'h40};
    logic [31:0] rv [8] = '{32'h0, 32'h0, 32'h0, 32'hff_ffff, 32'h0, 32'h1, 32'h0, 32'h0};
    logic [31:0] ov [8] = '{32'he5f, 32'hffff, 32'hf, 32'hff_ffff, 32'h0, 32'h1, 32'h0, 32'h0};
    int fb [6] = '{11, 10, 5, 4, 3, 2};
    assign {i_rx_break, i_autobaud_done, i_rx_addr_match, i_rx_parity_err, i_rx_frame_err, i_rx_done} = ev;
    uart_register_status_bank DUT (.*);
    tx_engine_model u_eng (.i_ref_clk(i_ref_clk), .i_valid(o_tx_valid), .o_take(i_tx_take),
        .o_busy(i_tx_shift_busy), .o_done(i_tx_done));
    initial begin
        i_ref_clk = 1'b0;
        forever #10 i_ref_clk = ~i_ref_clk;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("wrong value at %0t: got %h, expected %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge i_ref_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1 chk(o_rdata & m, e);
    endtask : rd
    task automatic give_verdict;
        $display("%0d compares, %0d mismatches", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict
    // ***********************************
    // stimulus
    // ***********************************
    initial begin
        {i_nrst, i_wr, i_rd, i_cts_pin, i_timer_run, i_timer_restart, ev} = 12'h000;
        {i_addr, i_wdata, i_rx_data, i_rx_parity} = 49'h0_0000_0000_0000 | 49'h1_4b;
        repeat (3) @(posedge i_ref_clk);
        i_nrst <= 1'b1;
        for (int k = 0; k < 8; k++) rd(ra[k], rv[k], 32'hffff_ffff);
        for (int k = 0; k < 8; k++) wr(ra[k], 32'hffff_ffff);
        for (int k = 0; k < 8; k++) rd(ra[k], ov[k], 32'hffff_ffff);
        chk({28'h0, o_baud_frac_part}, 32'hf);
        wr(OFS_IRQ_ENABLE, 32'h0);
        $display("register test done");
        wr(OFS_TRANSMIT, 32'h1a5);
        rd(OFS_IRQ_FLAG, 32'h100, 32'h103);
        w = 0;
        while (i_tx_done !== 1'b1 && w < 100) begin
            @(posedge i_ref_clk);
            #1 w++;
        end
        if (w == 100) begin
            failures++;
        end
        rd(OFS_IRQ_FLAG, 32'h003, 32'h103);
        $display("transmit test done");
        wr(OFS_TIMER_RELOAD, 32'h5);
        i_timer_restart <= 1'b1;
        @(posedge i_ref_clk);
        i_timer_restart <= 1'b0;
        i_timer_run <= 1'b1;
        repeat (10) @(posedge i_ref_clk);
        i_timer_run <= 1'b0;
        rd(OFS_TIMER_COUNT, 32'h5, 32'hffff_ffff);
        rd(OFS_IRQ_FLAG, 32'h200, 32'h200);
        wr(OFS_TIMER_RELOAD, 32'h100);
        wr(OFS_FLAG_CLEAR, 32'hffff_fdff);
        rd(OFS_IRQ_FLAG, 32'h0, 32'h200);
        i_cts_pin <= 1'b1;
        repeat (4) @(posedge i_ref_clk);
        rd(OFS_IRQ_FLAG, 32'hc0, 32'hc0);
        $display("timer and cts test done");
        wr(OFS_MODE, 32'h3);
        #1 chk({30'h0, o_lin_mode, o_tx_custom_parity}, 32'h3);
        wr(OFS_TRANSMIT, 32'h1a5);
        #1 chk({31'h0, o_tx_parity_bit}, 32'h1);
        chk({23'h0, o_break_bit_times}, 32'h1a5);
        for (int k = 0; k < 6; k++) begin
            wr(OFS_IRQ_ENABLE, 32'h1 << fb[k]);
            ev <= 6'h20 >> k;
            @(posedge i_ref_clk);
            ev <= 6'h00;
            #1 chk({31'h0, o_irq}, {31'h0, fb[k] != 5});
            rd(OFS_IRQ_FLAG, 32'h1 << fb[k], 32'h1 << fb[k]);
            if (fb[k] == 5) rd(OFS_RECEIVE, 32'h0, 32'hffff_ffff);
            else wr(OFS_FLAG_CLEAR, ~(32'h1 << fb[k]));
            rd(OFS_IRQ_FLAG, 32'h0, 32'h1 << fb[k]);
        end
        rd(OFS_RECEIVE, 32'h1a5, 32'hffff_ffff);
        $display("event test done");
        give_verdict();
    end
endmodule : test_uart_register_status_bank
bind uart_register_status_bank uart_regbank_props u_props (.*);
